//--- dpso_cfg.svh
/*
 * Constants of the DP slave output sync and response monitor block.
 * Assumes a frame decoder on sys_clk_i that delivers one-cycle frame strobes.
 */
`ifndef DPSO_CFG_SVH
`define DPSO_CFG_SVH
`define DPSO_OUT_W        8
`define DPSO_ADDR_W       7
`define DPSO_ADDR_MIN     7'h01
`define DPSO_ADDR_MAX     7'h7D
`define DPSO_ADDR_SERVICE 7'h00
`define DPSO_CLK_NS       100
`define DPSO_WD_W         24
`define DPSO_WD_UNIT_NS   10000000
`endif

//--- dpso_master_model.sv
/*
 * Master-side model driving decoded frame strobes into the output core.
 * Assumes the bench supplies the system clock.
 */
`timescale 1ns/1ns
module dpso_master_model (
	input  wire logic            sys_clk_i,
	input  wire logic            accept_i,
	output logic                 frm_valid_o,
	output dpso_pkg::dpso_addr_t frm_addr_o,
	output logic                 frm_group_o,
	output dpso_pkg::dpso_data_t frm_data_o,
	output logic                 frm_has_data_o,
	output logic                 cmd_sync_o,
	output logic                 cmd_unsync_o
);
	import dpso_pkg::*;
	logic acc;
	initial begin
		frm_valid_o = 1'b0;
		frm_addr_o = 7'h00;
		frm_group_o = 1'b0;
		frm_data_o = 8'h00;
		frm_has_data_o = 1'b0;
		cmd_sync_o = 1'b0;
		cmd_unsync_o = 1'b0;
		acc = 1'b0;
	end
	// Commands only ride on group frames
	task automatic send(input dpso_addr_t a, input logic g, s, u, h, input dpso_data_t d);
		@(posedge sys_clk_i);
		frm_valid_o <= 1'b1;
		frm_addr_o <= a;
		frm_group_o <= g;
		cmd_sync_o <= s & g;
		cmd_unsync_o <= u & g;
		frm_has_data_o <= h;
		frm_data_o <= d;
		#1 acc = accept_i;
		@(posedge sys_clk_i);
		frm_valid_o <= 1'b0;
		frm_addr_o <= ~a;
		frm_data_o <= ~d;
		cmd_sync_o <= 1'b0;
		cmd_unsync_o <= 1'b0;
		frm_has_data_o <= 1'b0;
		#1;
	endtask : send
endmodule : dpso_master_model

//--- dpso_output_core.sv
/*
 * DP slave output stage: address filter, SYNC/UNSYNC handling, output buffer,
 * response monitoring to a safe zero state.
 * Assumes frame strobes are one-cycle pulses from logic on sys_clk_i, and the
 * station address pins are static straps from outside, hence synchronised.
 */
`timescale 1ns/1ns
`include "dpso_cfg.svh"
module dpso_output_core (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rstn_i,
	input  wire dpso_pkg::dpso_addr_t station_addr_i,
	input  wire logic [`DPSO_WD_W-1:0] wd_cycles_i,
	input  wire logic                 frm_valid_i,
	input  wire dpso_pkg::dpso_addr_t frm_addr_i,
	input  wire logic                 frm_group_i,
	input  wire dpso_pkg::dpso_data_t frm_data_i,
	input  wire logic                 frm_has_data_i,
	input  wire logic                 cmd_sync_i,
	input  wire logic                 cmd_unsync_i,
	output logic                      accept_o,
	output dpso_pkg::dpso_data_t      out_o,
	output logic                      synced_o,
	output logic                      safe_o,
	output logic                      buf_full_o,
	output logic                      addr_ok_o
);
	import dpso_pkg::*;

	function automatic logic addr_legal(input dpso_addr_t a);
		return (a >= `DPSO_ADDR_MIN) && (a <= `DPSO_ADDR_MAX);
	endfunction : addr_legal

	dpso_addr_t addr_m_q, addr_s_q;
	dpso_mode_e mode_q, mode_d;
	dpso_data_t out_q, out_d, buf_q, buf_d;
	logic       bufv_q, bufv_d;
	logic       own, hit;
	logic       sync_ev, unsync_ev;

	dpso_wd_if wdc ();

	dpso_watchdog u_wd (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.limit_i   (wd_cycles_i),
		.wd        (wdc.wd)
	);

	// Address straps come from pins
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			addr_m_q <= `DPSO_ADDR_SERVICE;
			addr_s_q <= `DPSO_ADDR_SERVICE;
		end else begin
			addr_m_q <= station_addr_i;
			addr_s_q <= addr_m_q;
		end
	end

	// Own unicast frame, legal address only; group commands also accepted
	assign own       = frm_valid_i && addr_legal(addr_s_q) && !frm_group_i && frm_addr_i == addr_s_q;
	assign hit       = frm_valid_i && addr_legal(addr_s_q) && (frm_group_i || frm_addr_i == addr_s_q);
	assign sync_ev   = hit && frm_group_i && cmd_sync_i;
	assign unsync_ev = hit && frm_group_i && cmd_unsync_i && !cmd_sync_i;
	assign wdc.kick  = own;

	always_comb begin
		mode_d = mode_q;
		out_d  = out_q;
		buf_d  = buf_q;
		bufv_d = bufv_q;
		// An own frame in the expiry cycle still counts as addressed
		if (wdc.expired && !own) begin
			mode_d = DPSO_SAFE;
			out_d  = '0;
			bufv_d = 1'b0;
		end else begin
			case (mode_q)
				DPSO_SAFE: begin
					if (own && frm_has_data_i) begin
						out_d  = frm_data_i;
						mode_d = DPSO_CYCLIC;
					end
				end
				DPSO_CYCLIC: begin
					if (sync_ev)
						mode_d = DPSO_SYNCED;
					else if (own && frm_has_data_i)
						out_d = frm_data_i;
				end
				DPSO_SYNCED: begin
					if (own && frm_has_data_i) begin
						buf_d  = frm_data_i;
						bufv_d = 1'b1;
					end
					if (sync_ev && bufv_q) begin
						out_d  = buf_q;
						bufv_d = own && frm_has_data_i;
					end
					if (unsync_ev) begin
						mode_d = DPSO_CYCLIC;
						if (bufv_q)
							out_d = buf_q;
						bufv_d = 1'b0;
					end
				end
				default: mode_d = DPSO_SAFE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			mode_q <= DPSO_SAFE;
			out_q  <= '0;
			buf_q  <= '0;
			bufv_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			out_q  <= out_d;
			buf_q  <= buf_d;
			bufv_q <= bufv_d;
		end
	end

	assign out_o      = out_q;
	assign synced_o   = (mode_q == DPSO_SYNCED);
	assign safe_o     = (mode_q == DPSO_SAFE);
	assign buf_full_o = bufv_q;
	assign accept_o   = hit;
	assign addr_ok_o  = addr_legal(addr_s_q);

	sequence s_sync_entry;
		(mode_q == DPSO_CYCLIC) && sync_ev && !wdc.expired;
	endsequence

	a_sync_holds: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_sync_entry |=> (mode_q == DPSO_SYNCED) && out_q == $past(out_q))
		else $error("outputs moved on SYNC entry");

	a_synced_frozen: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(mode_q == DPSO_SYNCED) && !sync_ev && !unsync_ev && !wdc.expired |=> $stable(out_q))
		else $error("outputs changed while synchronised");

	a_buffer_capture: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(mode_q == DPSO_SYNCED) && own && frm_has_data_i && !wdc.expired
		|=> bufv_q && buf_q == $past(frm_data_i))
		else $error("frame data not buffered");

	a_sync_apply: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(mode_q == DPSO_SYNCED) && sync_ev && bufv_q && !wdc.expired |=> out_q == $past(buf_q))
		else $error("buffer not applied on SYNC");

	a_unsync_exit: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(mode_q == DPSO_SYNCED) && unsync_ev && !wdc.expired |=> mode_q == DPSO_CYCLIC)
		else $error("UNSYNC did not leave sync mode");

	a_safe_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		wdc.expired && !own |=> out_q == '0 && safe_o)
		else $error("outputs not zero in safe state");

	a_foreign_ignored: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		frm_valid_i && !frm_group_i && frm_addr_i != addr_s_q && mode_q == DPSO_CYCLIC
		&& !wdc.expired |=> $stable(out_q))
		else $error("foreign frame changed outputs");

	a_service_addr: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		addr_s_q == `DPSO_ADDR_SERVICE |-> !accept_o)
		else $error("frame accepted at service address");

	a_reset_safe: assert property (@(posedge sys_clk_i)
		!rstn_i |=> safe_o && out_q == '0 && !bufv_q)
		else $error("reset state not safe");

	sequence s_safe_leave;
		(mode_q == DPSO_SAFE) && own && frm_has_data_i;
	endsequence

	sequence s_cyclic_data;
		(mode_q == DPSO_CYCLIC) && own && frm_has_data_i;
	endsequence

	sequence s_sync_empty;
		(mode_q == DPSO_SYNCED) && sync_ev && !bufv_q && !wdc.expired;
	endsequence

	sequence s_unsync_pending;
		(mode_q == DPSO_SYNCED) && unsync_ev && bufv_q && !wdc.expired;
	endsequence

	a_safe_leave: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_safe_leave |=> (mode_q == DPSO_CYCLIC) && out_q == $past(frm_data_i))
		else $error("first data frame did not leave safe state");

	a_cyclic_update: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_cyclic_data |=> out_q == $past(frm_data_i))
		else $error("cyclic data not applied");

	a_unsync_apply: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_unsync_pending |=> out_q == $past(buf_q) && !bufv_q)
		else $error("pending buffer not applied on UNSYNC");

	a_sync_empty: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_sync_empty |=> $stable(out_q) && (mode_q == DPSO_SYNCED))
		else $error("SYNC with empty buffer moved outputs");

	a_sync_beats_unsync: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(mode_q == DPSO_SYNCED) && sync_ev && cmd_unsync_i && !wdc.expired |=> mode_q == DPSO_SYNCED)
		else $error("UNSYNC overrode SYNC");

	a_buf_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(mode_q == DPSO_SYNCED) && !own && !sync_ev && !unsync_ev && !wdc.expired
		|=> $stable(buf_q) && $stable(bufv_q))
		else $error("buffer changed without own data");

	a_safe_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(mode_q == DPSO_SAFE) && !(own && frm_has_data_i) |=> out_q == '0 && safe_o)
		else $error("outputs left zero while safe");

	a_illegal_refused: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!addr_ok_o |-> !accept_o)
		else $error("frame accepted at illegal address");
endmodule : dpso_output_core

//--- dpso_pkg.sv
/*
 * Types of the DP slave output block.
 * Assumes dpso_cfg.svh is included first.
 */
`include "dpso_cfg.svh"
package dpso_pkg;
	typedef logic [`DPSO_OUT_W-1:0]  dpso_data_t;
	typedef logic [`DPSO_ADDR_W-1:0] dpso_addr_t;
	typedef enum logic [1:0] {
		DPSO_CYCLIC = 2'b00,
		DPSO_SYNCED = 2'b01,
		DPSO_SAFE   = 2'b10
	} dpso_mode_e;
endpackage : dpso_pkg

//--- dpso_watchdog.sv
/*
 * Response monitoring timer; counts cycles since the last own-address frame.
 * Assumes limit_i is stable and nonzero.
 */
`timescale 1ns/1ns
`include "dpso_cfg.svh"
module dpso_watchdog (
	input  wire logic                   sys_clk_i,
	input  wire logic                   rstn_i,
	input  wire logic [`DPSO_WD_W-1:0]  limit_i,
	dpso_wd_if.wd                       wd
);
	logic [`DPSO_WD_W-1:0] cnt_q, cnt_d;
	logic                  exp_q, exp_d;

	always_comb begin
		cnt_d = cnt_q;
		exp_d = exp_q;
		if (wd.kick) begin
			cnt_d = '0;
			exp_d = 1'b0;
		end else if (!exp_q) begin
			if (cnt_q >= limit_i - `DPSO_WD_W'(1))
				exp_d = 1'b1;
			else
				cnt_d = cnt_q + `DPSO_WD_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign wd.expired = exp_q;

	a_wd_no_early: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		wd.kick |=> !wd.expired)
		else $error("watchdog expired right after a kick");
endmodule : dpso_watchdog

//--- dpso_wd_if.sv
/*
 * Interface between the output core and its response watchdog.
 * Assumes one clock domain.
 */
`timescale 1ns/1ns
interface dpso_wd_if;
	logic kick;
	logic expired;
	modport core (output kick, input expired);
	modport wd   (input kick, output expired);
endinterface : dpso_wd_if

//--- tb.sv
/*
 * Self-checking bench for the output core.
 * Assumes the master model feeds all frame inputs.
 */
`timescale 1ns/1ns
`include "dpso_cfg.svh"
module tb;
	import dpso_pkg::*;
	localparam int WD = 20;
	localparam dpso_addr_t ME = `DPSO_ADDR_MAX;
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       v, g, hd, sy, un, acc, syn, sf, bf, aok;
	dpso_addr_t fa;
	dpso_data_t fd, q;
	dpso_addr_t sa = ME;
	int         failures = 0;
	int         n_compared = 0;
	always #50 sys_clk = ~sys_clk;
	dpso_output_core u_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .station_addr_i(sa),
		.wd_cycles_i(WD[`DPSO_WD_W-1:0]), .frm_valid_i(v), .frm_addr_i(fa), .frm_group_i(g),
		.frm_data_i(fd), .frm_has_data_i(hd), .cmd_sync_i(sy), .cmd_unsync_i(un), .accept_o(acc),
		.out_o(q), .synced_o(syn), .safe_o(sf), .buf_full_o(bf), .addr_ok_o(aok));
	dpso_master_model u_mst (.sys_clk_i(sys_clk), .accept_i(acc), .frm_valid_o(v), .frm_addr_o(fa),
		.frm_group_o(g), .frm_data_o(fd), .frm_has_data_o(hd), .cmd_sync_o(sy), .cmd_unsync_o(un));
	task automatic chk(input dpso_data_t got, input dpso_data_t exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t flag got %b exp %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic t_reset;
		chk(q, 8'h00);
		chk_bit(sf, 1'b1);
		chk_bit(syn, 1'b0);
		chk_bit(bf, 1'b0);
		chk_bit(aok, 1'b1);
	endtask : t_reset
	task automatic t_cyclic;
		u_mst.send(ME, 1'b0, 1'b0, 1'b0, 1'b1, 8'hA5);
		chk_bit(u_mst.acc, 1'b1);
		chk(q, 8'hA5);
		chk_bit(sf, 1'b0);
		u_mst.send(7'h7E, 1'b0, 1'b0, 1'b0, 1'b1, 8'h3C);
		chk_bit(u_mst.acc, 1'b0);
		chk(q, 8'hA5);
	endtask : t_cyclic
	task automatic t_sync;
		u_mst.send(7'h7F, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
		chk_bit(syn, 1'b1);
		chk(q, 8'hA5);
		u_mst.send(ME, 1'b0, 1'b0, 1'b0, 1'b1, 8'h5A);
		chk(q, 8'hA5);
		chk_bit(bf, 1'b1);
		u_mst.send(7'h7F, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
		chk(q, 8'h5A);
		chk_bit(bf, 1'b0);
		chk_bit(syn, 1'b1);
		// SYNC and UNSYNC together, buffer empty: SYNC wins, outputs kept
		u_mst.send(7'h7F, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
		chk_bit(syn, 1'b1);
		chk(q, 8'h5A);
		u_mst.send(ME, 1'b0, 1'b0, 1'b0, 1'b1, 8'hC3);
		chk(q, 8'h5A);
		u_mst.send(7'h7F, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
		chk_bit(syn, 1'b0);
		chk(q, 8'hC3);
		u_mst.send(ME, 1'b0, 1'b0, 1'b0, 1'b1, 8'h81);
		chk(q, 8'h81);
	endtask : t_sync
	task automatic t_watchdog;
		// Expiry WD cycles after the last own frame, safe one cycle later
		repeat (WD) @(posedge sys_clk);
		#1 chk_bit(sf, 1'b0);
		chk(q, 8'h81);
		@(posedge sys_clk);
		#1 chk_bit(sf, 1'b1);
		chk(q, 8'h00);
		u_mst.send(ME, 1'b0, 1'b0, 1'b0, 1'b1, 8'h42);
		chk_bit(u_mst.acc, 1'b1);
		chk_bit(sf, 1'b0);
		chk(q, 8'h42);
	endtask : t_watchdog
	task automatic t_addr;
		@(posedge sys_clk);
		sa <= 7'h7E;
		repeat (2) @(posedge sys_clk);
		#1 chk_bit(aok, 1'b0);
		u_mst.send(7'h7E, 1'b0, 1'b0, 1'b0, 1'b1, 8'h99);
		chk_bit(u_mst.acc, 1'b0);
		chk(q, 8'h42);
		u_mst.send(7'h7F, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
		chk_bit(u_mst.acc, 1'b0);
		chk_bit(syn, 1'b0);
		@(posedge sys_clk);
		sa <= ME;
		repeat (2) @(posedge sys_clk);
		#1 chk_bit(aok, 1'b1);
	endtask : t_addr
	task automatic t_midreset;
		u_mst.send(7'h7F, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
		chk_bit(syn, 1'b1);
		u_mst.send(ME, 1'b0, 1'b0, 1'b0, 1'b1, 8'h66);
		chk_bit(bf, 1'b1);
		chk(q, 8'h42);
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 t_reset();
	endtask : t_midreset
	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 t_reset();
		t_cyclic();
		t_sync();
		t_watchdog();
		t_addr();
		t_midreset();
		summarize();
	end
	initial begin
		repeat (500) @(posedge sys_clk);
		failures++;
		summarize();
	end
endmodule : tb
